/* hdl/tqb_builder.sv */
// qualifier builder for telecontrol master commands; checks a configured record and
// emits type, qualifier and point value, reading the point database only where needed
// assumes one clock domain; the host holds the record stable while cmd_valid is high
// What this block does
// RL1: reset process qualifier 1 general, 2 event buffer
// RL2: reset process reads no database value
// RL3: parameter setting types 110, 111, 112
// RL4: parameter kind in bits 0 to 5
// RL5: kinds 5-31 reserved, 32-63 private
// RL6: bit 6 local change, bit 7 not operating
// RL7: parameter setting takes value from database
// RL8: activation qualifier bits 0-7, values 1-3
// RL9: activation 4-127 reserved, 128-255 private
// RL10: bit 8 activates, bits 9-15 unused
// RL11: activation reads no database value
// RL12: bcd setpoint takes six database bytes
// RL13: bcd qualifier 0 direct, 1 select, 2 deselect
// RL14: class 2 poll: no qualifier, no database
// RL15: bad qualifier raises error, nothing sent
`timescale 1ns/1ps
`default_nettype none
module tqb_builder #(
  parameter int AW = 8 // point address width
) (
  input wire logic clk_sys, // system clock, 250 MHz
  input wire logic rst_n, // synchronous reset, active low
  input wire logic cmd_valid, // command record offered
  output logic cmd_ready, // builder idle, a valid record is taken this cycle
  input wire logic [7:0] cmd_type, // command type code
  input wire logic [15:0] cmd_qual, // configured qualifier
  input wire logic [AW-1:0] cmd_point, // database point address
  input wire logic db_wr_en, // database write strobe
  input wire logic [AW-1:0] db_wr_addr, // database write address
  input wire logic [47:0] db_wr_data, // database write data
  output logic out_valid, // built command ready to send
  input wire logic out_ready, // link side accepts the command
  output logic [7:0] out_type, // type code sent
  output logic [15:0] out_qual, // qualifier sent
  output logic [47:0] out_value, // point value sent, zero if none
  output logic out_db_used, // value came from database
  output logic cfg_err, // one-cycle pulse: record refused
  output logic [2:0] cfg_err_code // reason of last refusal
);
  // refuse address widths that the point memory cannot be built for
  if (AW < 1 || AW > 16) begin : g_bad_aw
    $error("tqb_builder: AW out of range");
  end

  // whole state in one record, so hold is a single assignment and reset takes three (clear, then state and err_code)
  typedef struct packed {
    tqb_pkg::tqb_state_t state; // sequencer state
    logic [7:0] typ; // latched type
    logic [15:0] qual; // latched qualifier
    logic [AW-1:0] point; // latched point
    logic [47:0] value; // latched value
    logic db_used; // database was read
    logic err; // refusal pulse
    logic [2:0] err_code; // last refusal reason
  } tqb_regs_t;

  tqb_regs_t r; // current state
  tqb_regs_t next_r; // next state
  logic [47:0] mem_rd; // database read data
  logic [2:0] chk; // check result for offered record
  logic need_db; // offered record needs database

  tqb_point_mem #(.DW(48), .AW(AW)) u_mem (
    .clk_sys(clk_sys),
    .wr_en(db_wr_en),
    .wr_addr(db_wr_addr),
    .wr_data(db_wr_data),
    .rd_addr(r.point),
    .rd_data(mem_rd)
  );

  // validate a qualifier against its command type
  function automatic logic [2:0] check_qual(input logic [7:0] t, input logic [15:0] q);
    logic [5:0] kind;
    logic [7:0] pq;
    kind = q[tqb_pkg::PS_KIND_LSB +: tqb_pkg::PS_KIND_W];
    pq = q[tqb_pkg::PA_QUAL_W-1:0];
    check_qual = tqb_pkg::ERR_NONE;
    if (t == tqb_pkg::TYP_RESET_PROC) begin
      if (q[15:8] != 8'h00) check_qual = tqb_pkg::ERR_BADBITS;
      else if (q[7:0] == 8'h00) check_qual = tqb_pkg::ERR_UNUSED; // RL15
      else if (q[7:0] > tqb_pkg::RP_EVBUF && q[7:0] < tqb_pkg::RP_PRIV_LO) begin
        check_qual = tqb_pkg::ERR_RESERVED; // RL1
      end
    end else if (t == tqb_pkg::TYP_PSET_NORM || t == tqb_pkg::TYP_PSET_SCAL ||
                 t == tqb_pkg::TYP_PSET_FLT) begin // RL3
      if (q[15:8] != 8'h00) check_qual = tqb_pkg::ERR_BADBITS; // RL6
      else if (kind == 6'h00) check_qual = tqb_pkg::ERR_UNUSED; // RL4
      else if (kind > tqb_pkg::PS_KIND_MAX_STD && kind < tqb_pkg::PS_KIND_PRIV_LO) begin
        check_qual = tqb_pkg::ERR_RESERVED; // RL5
      end
    end else if (t == tqb_pkg::TYP_PACT) begin
      if (q[15:tqb_pkg::PA_ACT_BIT+1] != 7'h00) check_qual = tqb_pkg::ERR_BADBITS; // RL10
      else if (pq == 8'h00) check_qual = tqb_pkg::ERR_UNUSED; // RL8
      else if (pq > tqb_pkg::PA_QUAL_MAX_STD && pq < tqb_pkg::PA_PRIV_LO) begin
        check_qual = tqb_pkg::ERR_RESERVED; // RL9
      end
    end else if (t == tqb_pkg::TYP_BCD_SET) begin
      if (q[15:2] != 14'h0000 || q[1:0] == 2'h3) begin
        check_qual = tqb_pkg::ERR_RESERVED; // RL13
      end
    end else if (t == tqb_pkg::TYP_CLASS2) begin
      if (q != 16'h0000) check_qual = tqb_pkg::ERR_BADBITS; // RL14
    end else begin
      check_qual = tqb_pkg::ERR_BADTYPE;
    end
  endfunction

  // which types pull a point value; reset, activation and poll never do
  function automatic logic uses_db(input logic [7:0] t);
    uses_db = (t == tqb_pkg::TYP_PSET_NORM) || (t == tqb_pkg::TYP_PSET_SCAL) ||
              (t == tqb_pkg::TYP_PSET_FLT) || (t == tqb_pkg::TYP_BCD_SET); // RL2 RL11 RL14
  endfunction

  assign chk = check_qual(cmd_type, cmd_qual);
  assign need_db = uses_db(cmd_type);

  // next state: take record, read database if needed, hold result until accepted
  always_comb begin
    next_r = r;
    next_r.err = 1'b0;
    case (r.state)
      tqb_pkg::TQB_IDLE: begin
        if (cmd_valid) begin
          if (chk != tqb_pkg::ERR_NONE) begin
            next_r.err = 1'b1; // RL15
            next_r.err_code = chk;
          end else begin
            next_r.typ = cmd_type;
            next_r.qual = cmd_qual;
            next_r.point = cmd_point;
            next_r.value = 48'h0;
            next_r.db_used = need_db;
            next_r.state = need_db ? tqb_pkg::TQB_READ : tqb_pkg::TQB_DONE;
          end
        end
      end
      tqb_pkg::TQB_READ: begin
        next_r.state = tqb_pkg::TQB_WAIT; // address applied to memory
      end
      tqb_pkg::TQB_WAIT: begin
        if (r.typ == tqb_pkg::TYP_BCD_SET) begin
          next_r.value = mem_rd; // RL12
        end else if (r.typ == tqb_pkg::TYP_PSET_FLT) begin
          next_r.value = {16'h0, mem_rd[31:0]}; // RL7
        end else begin
          next_r.value = {32'h0, mem_rd[15:0]}; // RL7
        end
        next_r.state = tqb_pkg::TQB_DONE;
      end
      tqb_pkg::TQB_DONE: begin
        if (out_ready) next_r.state = tqb_pkg::TQB_IDLE;
      end
      default: begin
        next_r.state = tqb_pkg::TQB_IDLE;
      end
    endcase
    if (!rst_n) begin
      next_r = '0;
      next_r.state = tqb_pkg::TQB_IDLE;
      next_r.err_code = tqb_pkg::ERR_NONE;
    end
  end

  // single state register
  always_ff @(posedge clk_sys) begin
    r <= next_r;
  end

  // handshake outputs decode the state; data outputs come straight from registers
  assign cmd_ready = (r.state == tqb_pkg::TQB_IDLE);
  assign out_valid = (r.state == tqb_pkg::TQB_DONE);
  assign out_type = r.typ;
  assign out_qual = r.qual;
  assign out_value = r.value;
  assign out_db_used = r.db_used;
  assign cfg_err = r.err;
  assign cfg_err_code = r.err_code;

  // a clean record taken from the host starts the reset, activation, parameter and bcd checks below
  sequence s_take_clean;
    cmd_valid && cmd_ready && chk == tqb_pkg::ERR_NONE;
  endsequence

  a_bad_refused: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL15
    cmd_valid && cmd_ready && chk != tqb_pkg::ERR_NONE |=> cfg_err && !out_valid)
    else $error("bad qualifier not refused");
  a_reset_nodb: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL2
    s_take_clean ##0 (cmd_type == tqb_pkg::TYP_RESET_PROC) |=> out_valid && !out_db_used)
    else $error("reset process used database");
  a_act_nodb: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL11
    s_take_clean ##0 (cmd_type == tqb_pkg::TYP_PACT) |=> out_valid && out_value == 48'h0)
    else $error("activation carried a value");
  a_poll_clean: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL14
    out_valid && out_type == tqb_pkg::TYP_CLASS2 |-> out_qual == 16'h0 && !out_db_used)
    else $error("class 2 poll not clean");
  a_pset_db: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL7
    s_take_clean ##0 (cmd_type == tqb_pkg::TYP_PSET_SCAL) |=> !out_valid ##2 out_valid)
    else $error("parameter setting skipped database");
  a_bcd_value: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL12
    s_take_clean ##0 (cmd_type == tqb_pkg::TYP_BCD_SET) |=> ##2 out_db_used &&
    out_value == $past(mem_rd))
    else $error("bcd value not from database");
  a_kind_range: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL5
    out_valid && out_type == tqb_pkg::TYP_PSET_NORM |->
    out_qual[5:0] != 6'h0 && !(out_qual[5:0] > 6'h04 && out_qual[5:0] < 6'h20))
    else $error("reserved parameter kind sent");
  a_act_bits: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL10
    out_valid && out_type == tqb_pkg::TYP_PACT |-> out_qual[15:9] == 7'h0 &&
    !(out_qual[7:0] > 8'h03 && out_qual[7:0] < 8'h80))
    else $error("activation qualifier out of range");
  a_result_holds: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL15
    out_valid && !out_ready |=> out_valid && $stable(out_qual) && $stable(out_type))
    else $error("result dropped before accepted");
  // the refusal flag is a pulse that only a refused offer can raise
  a_err_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL15
    !(cmd_valid && cmd_ready) |=> !cfg_err)
    else $error("refusal pulse without a refused record");
endmodule
`default_nettype wire

/* hdl/tqb_point_mem.sv */
// point database memory, one word per address, registered read data
// assumes a single clock; write and read may happen in the same cycle
`timescale 1ns/1ps
`default_nettype none
module tqb_point_mem #(
  parameter int DW = 48, // word width
  parameter int AW = 8 // address width
) (
  input wire logic clk_sys, // system clock
  input wire logic wr_en, // write strobe
  input wire logic [AW-1:0] wr_addr, // write address
  input wire logic [DW-1:0] wr_data, // write data
  input wire logic [AW-1:0] rd_addr, // read address
  output logic [DW-1:0] rd_data // read data, one cycle after address
);
  // refuse sizes that make no usable array
  if (DW < 1 || AW < 1 || AW > 16) begin : g_bad_size
    $error("tqb_point_mem: size out of range");
  end

  logic [DW-1:0] mem [0:(1<<AW)-1]; // storage, no reset needed

  // write port and registered read port
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

/* include/tqb_pkg.sv */
// package for the telecontrol qualifier builder: command codes, qualifier fields, error codes
// assumes one clock domain; used by hdl/tqb_builder.sv, not by hdl/tqb_point_mem.sv
package tqb_pkg;
  // command type codes
  localparam logic [7:0] TYP_RESET_PROC = 8'h69; // 105 reset process
  localparam logic [7:0] TYP_PSET_NORM = 8'h6e; // 110 parameter normalized
  localparam logic [7:0] TYP_PSET_SCAL = 8'h6f; // 111 parameter scaled
  localparam logic [7:0] TYP_PSET_FLT = 8'h70; // 112 parameter short float
  localparam logic [7:0] TYP_PACT = 8'h71; // 113 parameter activation
  localparam logic [7:0] TYP_BCD_SET = 8'hf2; // 242 bcd integrated total setpoint
  localparam logic [7:0] TYP_CLASS2 = 8'hff; // 255 class 2 poll
  // reset process qualifier codes
  localparam logic [7:0] RP_GENERAL = 8'h01; // general reset of process
  localparam logic [7:0] RP_EVBUF = 8'h02; // reset time tagged event buffer
  localparam logic [7:0] RP_PRIV_LO = 8'h80; // private range start
  // parameter setting qualifier fields
  localparam int PS_KIND_LSB = 0; // kind field low bit
  localparam int PS_KIND_W = 6; // kind field width
  localparam int PS_LOCAL_BIT = 6; // local change
  localparam int PS_OPER_BIT = 7; // not in operation
  localparam logic [5:0] PS_KIND_MAX_STD = 6'h04; // highest standard kind
  localparam logic [5:0] PS_KIND_PRIV_LO = 6'h20; // private kind start
  // parameter activation qualifier fields
  localparam int PA_QUAL_W = 8; // parameter qualifier width
  localparam int PA_ACT_BIT = 8; // activate bit
  localparam logic [7:0] PA_QUAL_MAX_STD = 8'h03; // highest defined value
  localparam logic [7:0] PA_PRIV_LO = 8'h80; // private range start
  // bcd setpoint sequence codes
  localparam logic [1:0] BCD_DIRECT = 2'h0; // execute without select
  localparam logic [1:0] BCD_SELECT = 2'h1; // select then execute
  localparam logic [1:0] BCD_DESEL = 2'h2; // deselect
  localparam int BCD_BYTES = 6; // database area size
  // error codes
  localparam logic [2:0] ERR_NONE = 3'h0; // accepted
  localparam logic [2:0] ERR_UNUSED = 3'h1; // unused code
  localparam logic [2:0] ERR_RESERVED = 3'h2; // reserved by standard
  localparam logic [2:0] ERR_BADBITS = 3'h3; // unused bits set
  localparam logic [2:0] ERR_BADTYPE = 3'h4; // unknown command type
  // builder states
  typedef enum logic [3:0] {
    TQB_IDLE = 4'b0001,
    TQB_READ = 4'b0010,
    TQB_WAIT = 4'b0100,
    TQB_DONE = 4'b1000
  } tqb_state_t;
endpackage

/* sim/testbench.sv */
// self-checking bench for the qualifier builder: table of records, then stall and reset cases
// assumes the builder contract of one record at a time and the link model in its own file
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [7:0] ty; // command type
    logic [15:0] q; // configured qualifier
    logic [2:0] code; // expected refusal code, 0 accepted
    logic [47:0] val; // expected value sent
  } tqb_row_t;
  localparam logic [47:0] V3 = 48'h123456789abc; // word at point 3
  localparam logic [47:0] V5 = 48'hfedcba987654; // word at point 5
  localparam tqb_row_t ROWS [27] = '{
    '{8'h69, 16'h0001, 3'h0, 48'h0}, '{8'h69, 16'h0002, 3'h0, 48'h0},
    '{8'h69, 16'h00ff, 3'h0, 48'h0}, '{8'h69, 16'h0000, 3'h1, 48'h0},
    '{8'h69, 16'h007f, 3'h2, 48'h0}, '{8'h69, 16'h0101, 3'h3, 48'h0},
    '{8'h6e, 16'h00c1, 3'h0, 48'h9abc}, '{8'h6f, 16'h0004, 3'h0, 48'h9abc},
    '{8'h70, 16'h0062, 3'h0, 48'h56789abc}, '{8'h6e, 16'h003f, 3'h0, 48'h9abc},
    '{8'h6f, 16'h0005, 3'h2, 48'h0}, '{8'h70, 16'h001f, 3'h2, 48'h0},
    '{8'h6e, 16'h0080, 3'h1, 48'h0}, '{8'h6f, 16'h8001, 3'h3, 48'h0},
    '{8'h71, 16'h0101, 3'h0, 48'h0}, '{8'h71, 16'h0003, 3'h0, 48'h0},
    '{8'h71, 16'h01ff, 3'h0, 48'h0}, '{8'h71, 16'h0004, 3'h2, 48'h0},
    '{8'h71, 16'h0100, 3'h1, 48'h0}, '{8'h71, 16'h0202, 3'h3, 48'h0},
    '{8'hf2, 16'h0000, 3'h0, V5}, '{8'hf2, 16'h0002, 3'h0, V5},
    '{8'hf2, 16'h0003, 3'h2, 48'h0}, '{8'hf2, 16'h0004, 3'h2, 48'h0},
    '{8'hff, 16'h0000, 3'h0, 48'h0}, '{8'hff, 16'h8000, 3'h3, 48'h0},
    '{8'h6d, 16'h0001, 3'h4, 48'h0}};
  logic clk_sys, rst_n, cmd_valid, cmd_ready, db_wr_en, out_valid, out_ready;
  logic out_db_used, cfg_err;
  logic [7:0] cmd_type, cmd_point, db_wr_addr, out_type;
  logic [15:0] cmd_qual, out_qual;
  logic [47:0] db_wr_data, out_value;
  logic [2:0] cfg_err_code;
  logic [3:0] stall; // consumer hold-off
  int n_fail, tests_run;
  tqb_builder #(.AW(8)) tqb_builder_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_type(cmd_type), .cmd_qual(cmd_qual),
    .cmd_point(cmd_point), .db_wr_en(db_wr_en), .db_wr_addr(db_wr_addr),
    .db_wr_data(db_wr_data), .out_valid(out_valid), .out_ready(out_ready),
    .out_type(out_type), .out_qual(out_qual), .out_value(out_value),
    .out_db_used(out_db_used), .cfg_err(cfg_err), .cfg_err_code(cfg_err_code));
  tqb_link_model tqb_link_model_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .out_valid(out_valid), .stall(stall), .out_ready(out_ready));
  // free-running system clock, 4 ns
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // compare and count; an unknown bit matches only an unknown bit
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // counts line, then the verdict
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one word into the point database, entered just after a rising edge
  task automatic db_write(input logic [7:0] a, input logic [47:0] d);
    db_wr_en = 1'b1;
    db_wr_addr = a;
    db_wr_data = d;
    @(posedge clk_sys);
    #1 db_wr_en = 1'b0;
    // one idle edge, so a following write never re-raises the strobe in the same step
    @(posedge clk_sys);
    #1;
  endtask
  // offer one record, follow it to its answer; entered and left just after a rising edge
  task automatic run(input tqb_row_t r);
    int n;
    logic used;
    logic [47:0] v0;
    used = (r.code == 3'h0) && (r.ty inside {8'h6e, 8'h6f, 8'h70, 8'hf2});
    cmd_valid = 1'b1;
    cmd_type = r.ty;
    cmd_qual = r.q;
    cmd_point = (r.ty == 8'hf2) ? 8'h05 : 8'h03;
    @(negedge clk_sys);
    check("cmd_ready idle", 48'(cmd_ready), 48'h1);
    @(posedge clk_sys);
    #1 cmd_valid = 1'b0;
    n = 0;
    @(negedge clk_sys);
    while (out_valid !== 1'b1 && cfg_err !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    v0 = out_value;
    if (r.code == 3'h0) begin
      check("latency", 48'(n), used ? 48'h2 : 48'h0);
      check("cmd_ready busy", 48'(cmd_ready), 48'h0);
      while (out_ready !== 1'b1 && n < 50) begin
        @(negedge clk_sys);
        n++;
      end
      check("out_valid", 48'(out_valid), 48'h1);
      check("out_type", 48'(out_type), 48'(r.ty));
      check("out_qual", 48'(out_qual), 48'(r.q));
      check("out_value", out_value, r.val);
      check("value held", out_value, v0);
      check("out_db_used", 48'(out_db_used), 48'(used));
    end else begin
      check("cfg_err", 48'(cfg_err), 48'h1);
      check("cfg_err_code", 48'(cfg_err_code), 48'(r.code));
      check("out_valid refused", 48'(out_valid), 48'h0);
    end
    if (n >= 50) begin
      n_fail++;
      test_done();
    end
    @(posedge clk_sys);
    #1;
    // taken or refused, the builder is idle again and the pulse has gone
    check("back to idle", 48'({cmd_ready, out_valid, cfg_err}), 48'h4);
  endtask
  // main sequence
  initial begin
    {rst_n, cmd_valid, db_wr_en, cmd_type, cmd_qual, cmd_point} = '0;
    {db_wr_addr, db_wr_data, stall, n_fail, tests_run} = '0;
    repeat (19) @(posedge clk_sys);
    @(negedge clk_sys);
    check("reset idle", 48'({cmd_ready, out_valid, cfg_err, cfg_err_code}), 48'h20);
    @(posedge clk_sys);
    #1 rst_n = 1'b1;
    db_write(8'h03, V3);
    db_write(8'h05, V5);
    foreach (ROWS[i]) run(ROWS[i]);
    // consumer holds off six cycles: the command must stand untouched
    stall = 4'h6;
    run('{8'hf2, 16'h0001, 3'h0, V5});
    stall = 4'h0;
    // a rewritten word reaches the next parameter command
    db_write(8'h03, V5);
    run('{8'h70, 16'h0001, 3'h0, 48'hba987654});
    // reset lands while a database read is in flight
    cmd_valid = 1'b1;
    cmd_type = 8'h6e;
    cmd_qual = 16'h0001;
    @(posedge clk_sys);
    #1 cmd_valid = 1'b0;
    rst_n = 1'b0;
    @(posedge clk_sys);
    #1 rst_n = 1'b1;
    @(negedge clk_sys);
    check("reset mid-run", 48'({cmd_ready, out_valid, cfg_err, cfg_err_code}), 48'h20);
    @(posedge clk_sys);
    #1;
    run(ROWS[0]);
    test_done();
  end
endmodule
`default_nettype wire

/* sim/tqb_link_model.sv */
// link-side consumer model: takes built commands after a programmable hold-off
// assumes one clock domain and that out_valid stands until it is accepted
`timescale 1ns/1ps
`default_nettype none
module tqb_link_model (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic out_valid, // command offered by the builder
  input wire logic [3:0] stall, // cycles to hold off before accepting
  output logic out_ready // consumer accepts the command
);
  logic [3:0] wait_cnt; // cycles the offer has stood unaccepted
  // ready drops right after each take so a stale ready never swallows the next command
  always_ff @(posedge clk_sys) begin
    if (!rst_n || (out_valid && out_ready)) begin
      wait_cnt <= 4'h0;
      out_ready <= 1'b0;
    end else if (out_valid) begin
      wait_cnt <= wait_cnt + 4'h1;
      out_ready <= (wait_cnt >= stall);
    end
  end
endmodule
`default_nettype wire
